// ==== inc/ifc_pkg.sv ====
// Package for the IF frequency / period counter block.
// Assumes a 125 MHz core clock and an AHB-Lite register bus.
package ifc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Clocking and reference time base
  localparam int unsigned CLK_HZ = 125000000;  // Core clock rate
  localparam int unsigned REF_HZ = 75000;  // Crystal reference rate
  // Core cycles per reference tick, rounded down
  localparam int unsigned REF_DIV = CLK_HZ / REF_HZ;

  ////////////////////////////////////////////////////////////////////////////
  // Counter and gate sizes
  localparam int unsigned CNT_W = 20;  // Result counter width
  localparam int unsigned GATE_W = 16;  // Gate tick counter width
  // Gate times in microseconds, one per gate select code
  localparam int unsigned GATE0_US = 1000;
  localparam int unsigned GATE1_US = 4000;
  localparam int unsigned GATE2_US = 8000;
  localparam int unsigned GATE3_US = 16000;
  // Gate times as reference ticks
  localparam logic [GATE_W-1:0] GATE0_TK = GATE_W'(GATE0_US * 3 / 40);
  localparam logic [GATE_W-1:0] GATE1_TK = GATE_W'(GATE1_US * 3 / 40);
  localparam logic [GATE_W-1:0] GATE2_TK = GATE_W'(GATE2_US * 3 / 40);
  localparam logic [GATE_W-1:0] GATE3_TK = GATE_W'(GATE3_US * 3 / 40);

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_RSLT = 8'h08;

  // Control register fields
  localparam int unsigned CTRL_W = 7;
  localparam int unsigned B_RUN = 0;  // count_run_bit
  localparam int unsigned B_MAN = 1;  // Manual gate
  localparam int unsigned B_GLO = 2;  // gate_select_low
  localparam int unsigned B_GHI = 3;  // gate_select_high
  localparam int unsigned B_PSEL = 4;  // period_input_select
  localparam int unsigned B_IFEN = 5;  // Shared pin routed to IF input
  localparam int unsigned B_PLLOFF = 6;  // PLL off mode
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;

  // Status register fields
  localparam int unsigned B_BUSY = 0;
  localparam int unsigned B_OVER = 1;

  // Counter engine states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ARM,
    ST_COUNT
  } ifc_state_type;

endpackage

// ==== inc/ifc_tick_if.sv ====
// Carrier for the reference tick between time base and counter.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface ifc_tick_if;
  logic tick;  // One-cycle 75 kHz enable
  modport src (output tick);
  modport snk (input tick);
endinterface

// ==== src/ifc_tbase.sv ====
// Reference time base: divides the core clock down to a 75 kHz enable.
// Assumes one core clock; the tick is a single-cycle pulse.
`timescale 1ns/1ps
module ifc_tbase
  import ifc_pkg::*;
#(
  parameter int unsigned DIV = REF_DIV
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // Tick out
  ifc_tick_if.src tk
);

  logic [15:0] div_ff;  // Divider count
  logic [15:0] nxt_div;
  logic tick_ff;  // Registered tick
  logic nxt_tick;

  // Next divider value and tick
  always_comb begin
    nxt_tick = 1'b0;
    nxt_div = div_ff + 16'h0001;
    if (div_ff == 16'(DIV - 1)) begin
      nxt_div = 16'h0000;
      nxt_tick = 1'b1;
    end
  end

  // Divider registers
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      div_ff <= 16'h0000;
      tick_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      tick_ff <= nxt_tick;
    end
  end

  assign tk.tick = tick_ff;

endmodule

// ==== src/ifc_counter.sv ====
// IF frequency / period counter with AHB-Lite register slave.
// Assumes inputs synchronous to core_clk_i and a single AHB master.
//
// Contract
// - Counter disabled in PLL off, except timer
// - Auto mode counts IF pulses for gate
// - Busy reads one while measuring
// - Overflow set when count exceeds 20 bits
// - Manual plus start begins counting
// - Manual mode stops when start cleared
// - Period mode counts reference from one pin rising edge to the next
// - Period select takes the dedicated pin
// - Period busy holds until pin pulses
// - Manual with both gates is timer
// - Timer clears on each start write
// - Start bit zero stops, one starts
`timescale 1ns/1ps
module ifc_counter
  import ifc_pkg::*;
#(
  parameter int unsigned DIV = REF_DIV  // Core cycles per reference tick
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rstn_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [31:0] hrdata_o,
  // Measured inputs
  input wire logic intermediate_freq_input_i,
  input wire logic period_input_pin_i
);

  ////////////////////////////////////////////////////////////////////////////
  // Time base
  ifc_tick_if tk_if ();  // Reference tick carrier
  ifc_tbase #(.DIV(DIV)) u_tbase (
    .core_clk_i(core_clk_i),
    .rstn_i(rstn_i),
    .tk(tk_if.src)
  );
  logic ref_tick;  // 75 kHz enable
  assign ref_tick = tk_if.tick;

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic wr_pend_ff, nxt_wr_pend;  // Write data phase pending
  logic [7:0] waddr_ff, nxt_waddr;  // Write address
  logic [CTRL_W-1:0] ctrl_ff, nxt_ctrl;  // Control register
  logic [31:0] rdata_ff, nxt_rdata;  // Read data
  ifc_state_type state_ff, nxt_state;  // Engine state
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;  // Result counter
  logic [GATE_W-1:0] gate_ff, nxt_gate;  // Gate tick count
  logic over_ff, nxt_over;  // Overflow flag
  logic busy_ff, nxt_busy;  // Busy flag
  logic in_ff, nxt_in;  // Previous measured level

  // Decode helpers
  logic start_wr, stop_wr;  // Start bit written one / zero
  logic mode_timer, mode_man, mode_per, enabled;
  logic sel_in, in_edge, do_inc, gate_end;
  logic [GATE_W-1:0] gate_len;  // Selected gate duration
  logic rd_phase;  // Read address phase taken

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic for bus, control and counter engine
  always_comb begin
    nxt_wr_pend = 1'b0;
    nxt_waddr = waddr_ff;
    nxt_ctrl = ctrl_ff;
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_gate = gate_ff;
    nxt_over = over_ff;
    nxt_rdata = rdata_ff;
    start_wr = 1'b0;
    stop_wr = 1'b0;
    do_inc = 1'b0;
    gate_end = 1'b0;
    // Address phase capture; zero wait states so hready is ours
    rd_phase = hsel_i && htrans_i[1] && hready_i && !hwrite_i;
    if (hsel_i && htrans_i[1] && hready_i && hwrite_i) begin
      nxt_wr_pend = 1'b1;
      nxt_waddr = haddr_i[7:0];
    end
    // Data phase of a control write; unmapped writes are dropped
    if (wr_pend_ff && waddr_ff == OFS_CTRL) begin
      nxt_ctrl = hwdata_i[CTRL_W-1:0];
      start_wr = hwdata_i[B_RUN];
      stop_wr = !hwdata_i[B_RUN];
    end
    // Mode decode follows the freshly written control bits
    mode_timer = nxt_ctrl[B_MAN] && nxt_ctrl[B_GLO]
                 && nxt_ctrl[B_GHI];
    mode_man = nxt_ctrl[B_MAN] && !mode_timer;
    mode_per = nxt_ctrl[B_PSEL] && !nxt_ctrl[B_MAN];
    enabled = !nxt_ctrl[B_PLLOFF] || mode_timer;
    // Source: dedicated pin, else IF pin when routed
    sel_in = nxt_ctrl[B_PSEL] ? period_input_pin_i
             : (intermediate_freq_input_i && nxt_ctrl[B_IFEN]);
    in_edge = sel_in && !in_ff;
    nxt_in = sel_in;
    // Gate duration per code
    case ({nxt_ctrl[B_GHI], nxt_ctrl[B_GLO]})
      2'b00: gate_len = GATE0_TK;
      2'b01: gate_len = GATE1_TK;
      2'b10: gate_len = GATE2_TK;
      default: gate_len = GATE3_TK;
    endcase
    // Counter engine
    if (!enabled) begin
      nxt_state = ST_IDLE;
    end else if (start_wr) begin
      // Fresh start clears result, flag and gate
      nxt_cnt = '0;
      nxt_over = 1'b0;
      nxt_gate = '0;
      nxt_state = mode_per ? ST_ARM : ST_COUNT;
    end else if (stop_wr) begin
      nxt_state = ST_IDLE;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          // Hold result
        end
        ST_ARM: begin
          // Wait for the pulse to open the period
          if (in_edge) begin
            nxt_state = ST_COUNT;
          end
        end
        ST_COUNT: begin
          if (mode_timer) begin
            do_inc = ref_tick;
          end else if (mode_man) begin
            do_inc = in_edge;
          end else if (mode_per) begin
            // Next edge closes the period
            if (in_edge) begin
              nxt_state = ST_IDLE;
            end else begin
              do_inc = ref_tick;
            end
          end else begin
            do_inc = in_edge;
            if (ref_tick) begin
              nxt_gate = gate_ff + GATE_W'(1);
              gate_end = (gate_ff == gate_len - GATE_W'(1));
              if (gate_end) begin
                nxt_state = ST_IDLE;
              end
            end
          end
        end
        default: nxt_state = ST_IDLE;
      endcase
    end
    // Wrap the counter and latch overflow
    if (do_inc) begin
      nxt_cnt = cnt_ff + CNT_W'(1);
      if (cnt_ff == {CNT_W{1'b1}}) begin
        nxt_over = 1'b1;
      end
    end
    nxt_busy = (nxt_state != ST_IDLE);
    // Read mux uses next values so a read after a write sees it
    if (rd_phase) begin
      case (haddr_i[7:0])
        OFS_CTRL: nxt_rdata = {{(32 - CTRL_W){1'b0}}, nxt_ctrl};
        OFS_STAT: nxt_rdata = {30'h00000000, nxt_over, nxt_busy};
        OFS_RSLT: nxt_rdata = {{(32 - CNT_W){1'b0}}, nxt_cnt};
        default: nxt_rdata = 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_pend_ff <= 1'b0;
      waddr_ff <= 8'h00;
      ctrl_ff <= CTRL_RST;
      rdata_ff <= 32'h00000000;
      state_ff <= ST_IDLE;
      cnt_ff <= '0;
      gate_ff <= '0;
      over_ff <= 1'b0;
      busy_ff <= 1'b0;
      in_ff <= 1'b0;
    end else begin
      wr_pend_ff <= nxt_wr_pend;
      waddr_ff <= nxt_waddr;
      ctrl_ff <= nxt_ctrl;
      rdata_ff <= nxt_rdata;
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      gate_ff <= nxt_gate;
      over_ff <= nxt_over;
      busy_ff <= nxt_busy;
      in_ff <= nxt_in;
    end
  end

  // Always ready, always OKAY; kept as flops to meet output style
  logic rdy_ff, resp_ff;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdy_ff <= 1'b1;
      resp_ff <= 1'b0;
    end else begin
      rdy_ff <= 1'b1;
      resp_ff <= 1'b0;
    end
  end
  assign hreadyout_o = rdy_ff;
  assign hresp_o = resp_ff;
  assign hrdata_o = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_top_tick;
    state_ff == ST_COUNT && ref_tick && !stop_wr && !start_wr;
  endsequence

  property p_pll_off;
    ctrl_ff[B_PLLOFF] && !(ctrl_ff[B_MAN] && ctrl_ff[B_GLO]
      && ctrl_ff[B_GHI]) |-> state_ff == ST_IDLE && !busy_ff;
  endproperty
  a_pll_off: assert property (p_pll_off)
    else $error("counter ran in PLL off");

  property p_gate_end;
    s_top_tick and (gate_end && enabled) |=> !busy_ff ##1 $stable(cnt_ff);
  endproperty
  a_gate_end: assert property (p_gate_end)
    else $error("auto gate did not stop counting");

  property p_busy;
    busy_ff == (state_ff != ST_IDLE);
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy does not match engine state");

  property p_over;
    do_inc && cnt_ff == {CNT_W{1'b1}} |=> over_ff && cnt_ff == '0;
  endproperty
  a_over: assert property (p_over)
    else $error("overflow not flagged");

  property p_start;
    start_wr && enabled && !mode_per |=> busy_ff && cnt_ff == '0
      && !over_ff;
  endproperty
  a_start: assert property (p_start)
    else $error("start did not begin counting");

  property p_stop;
    stop_wr && state_ff == ST_COUNT |=> !busy_ff ##1 $stable(cnt_ff);
  endproperty
  a_stop: assert property (p_stop)
    else $error("stop did not halt counting");

  property p_period;
    s_top_tick and (mode_per && !in_edge && enabled)
      |=> cnt_ff == $past(cnt_ff) + CNT_W'(1);
  endproperty
  a_period: assert property (p_period)
    else $error("period count missed a reference tick");

  property p_arm;
    state_ff == ST_ARM && !in_edge && !stop_wr && enabled |=> busy_ff;
  endproperty
  a_arm: assert property (p_arm)
    else $error("busy fell before period pulse");

  property p_timer;
    s_top_tick and mode_timer |=> cnt_ff == $past(cnt_ff) + CNT_W'(1);
  endproperty
  a_timer: assert property (p_timer)
    else $error("timer missed a reference tick");

endmodule

// ==== sim/ifc_sig_src.sv ====
// Far-side model: IF pulse source and low-frequency period pulse source.
// Assumes the bench sets the half period and the pulse spacing; 0 = quiet.
`timescale 1ns/1ps
module ifc_sig_src (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Controls from the bench
  input wire logic [15:0] if_half_i,
  input wire logic [15:0] pin_per_i,
  // Generated signals
  output logic if_o,
  output logic pin_o
);
  logic [15:0] if_cnt_ff;  // Cycles into current IF half period
  logic [15:0] pin_cnt_ff;  // Cycles into current pin period

  ////////////////////////////////////////////////////////////////////////////
  // Square wave on IF, short high pulse on the pin; a real source idles low
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      if_cnt_ff <= 16'h0;
      pin_cnt_ff <= 16'h0;
      if_o <= 1'h0;
      pin_o <= 1'h0;
    end else begin
      if (if_half_i == 16'h0) begin
        if_cnt_ff <= 16'h0;
        if_o <= 1'h0;
      end else if (if_cnt_ff + 16'h1 >= if_half_i) begin
        if_cnt_ff <= 16'h0;
        if_o <= ~if_o;
      end else begin
        if_cnt_ff <= if_cnt_ff + 16'h1;
      end
      // Pin high for four cycles so each level lasts over one cycle
      if (pin_per_i == 16'h0) begin
        pin_cnt_ff <= 16'h0;
        pin_o <= 1'h0;
      end else begin
        pin_cnt_ff <= (pin_cnt_ff + 16'h1 >= pin_per_i) ? 16'h0 :
                      pin_cnt_ff + 16'h1;
        pin_o <= (pin_cnt_ff < 16'h4);
      end
    end
  end
endmodule

// ==== sim/if_frequency_period_counter_test.sv ====
// Self-checking bench for the IF frequency / period counter.
// Assumes a zero-wait AHB-Lite slave and a shortened reference tick.
`timescale 1ns/1ps
module if_frequency_period_counter_test;
  import ifc_pkg::*;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d;
                  logic [31:0] e;} ifc_row_type;
  logic clk = 1'h0;
  logic rstn = 1'h0;
  logic hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp;
  logic [31:0] hrdata, q, r;
  logic if_sig, pin_sig;
  logic [15:0] if_half = 16'h0;  // IF source half period
  logic [15:0] pin_per = 16'h0;  // Pin pulse spacing
  int miscompares = 0;
  int samples_checked = 0;
  int cyc = 0;
  // Short tick keeps the 75-tick gate within the cycle budget
  localparam int tk = 40;
  ifc_row_type rows [7];

  ////////////////////////////////////////////////////////////////////////////
  ifc_counter #(.DIV(tk)) u_ifc_counter (.core_clk_i(clk), .rstn_i(rstn),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout),
    .hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata),
    .intermediate_freq_input_i(if_sig), .period_input_pin_i(pin_sig));
  ifc_sig_src u_ifc_sig_src (.clk_i(clk), .rstn_i(rstn),
    .if_half_i(if_half), .pin_per_i(pin_per), .if_o(if_sig),
    .pin_o(pin_sig));

  always #4 clk = ~clk;
  // Hang guard well above the roughly 10k cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task give_verdict();
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    samples_checked++;
    if (seen !== ex) begin
      miscompares++;
      $display("[ERR] %s exp %h seen %h", nm, ex, seen);
    end
  endtask
  // One single transfer: address phase, then data phase, hready-gated
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
           output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge clk);
    while (hreadyout !== 1'h1) @(posedge clk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hreadyout !== 1'h1) @(posedge clk);
    rd = hrdata;
  endtask
  task wait_idle(input int lim);
    int n;
    n = 0;
    q = 32'h1;
    while (q[B_BUSY] !== 1'h0 && n < lim) begin
      bus(1'h0, OFS_STAT, 32'h0, q);
      n++;
    end
    chk("busy clears", q[B_BUSY], 1'h0);
    chk("overflow", q[B_OVER], 1'h0);
  endtask
  function automatic logic [31:0] inr(input logic [31:0] v, input int lo,
                                      input int hi);
    inr = (v >= lo && v <= hi) ? 32'h1 : 32'h0;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rows = '{'{1'h0, OFS_CTRL, 32'h0, 32'h0}, '{1'h0, OFS_STAT, 32'h0, 32'h0},
      '{1'h0, OFS_RSLT, 32'h0, 32'h0}, '{1'h1, 8'h0C, 32'hFF, 32'h0},
      '{1'h0, 8'h0C, 32'h0, 32'h0}, '{1'h1, OFS_CTRL, 32'h7E, 32'h0},
      '{1'h0, OFS_CTRL, 32'h0, 32'h7E}};
    repeat (3) @(posedge clk);
    rstn <= 1'h1;
    foreach (rows[i]) begin
      bus(rows[i].w, rows[i].a, rows[i].d, q);
      if (!rows[i].w) chk("register row", q, rows[i].e);
    end
    $display("register table done");
    // Manual gate, opened and closed by software
    if_half <= 16'h000A;
    bus(1'h1, OFS_CTRL, 32'h23, q);
    bus(1'h0, OFS_STAT, 32'h0, q);
    chk("manual busy", q[B_BUSY], 1'h1);
    repeat (994) @(posedge clk);
    bus(1'h1, OFS_CTRL, 32'h22, q);
    bus(1'h0, OFS_RSLT, 32'h0, q);
    repeat (500) @(posedge clk);
    bus(1'h0, OFS_RSLT, 32'h0, r);
    chk("manual count", inr(q, 48, 53), 32'h1);
    chk("manual hold", r, q);
    bus(1'h1, OFS_CTRL, 32'h61, q);
    repeat (2000) @(posedge clk);
    bus(1'h0, OFS_STAT, 32'h0, q);
    chk("pll off busy", q[B_BUSY], 1'h0);
    bus(1'h0, OFS_RSLT, 32'h0, q);
    chk("pll off count", q, r);
    $display("manual and pll off done");
    // Period mode: pin quiet keeps busy, IF edges ignored
    bus(1'h1, OFS_CTRL, 32'h31, q);
    repeat (3000) @(posedge clk);
    bus(1'h0, OFS_STAT, 32'h0, q);
    chk("period busy", q[B_BUSY], 1'h1);
    bus(1'h0, OFS_RSLT, 32'h0, q);
    chk("if ignored", q, 32'h0);
    pin_per <= 16'(3 * tk);
    wait_idle(8000);
    bus(1'h0, OFS_RSLT, 32'h0, q);
    chk("period ticks", inr(q, 2, 4), 32'h1);
    pin_per <= 16'h0;
    $display("period done");
    // Timer under PLL off still counts; each start clears it
    bus(1'h1, OFS_CTRL, 32'h4F, q);
    repeat (5 * tk) @(posedge clk);
    bus(1'h0, OFS_RSLT, 32'h0, q);
    chk("timer ticks", inr(q, 4, 6), 32'h1);
    bus(1'h1, OFS_CTRL, 32'h4F, q);
    bus(1'h0, OFS_RSLT, 32'h0, q);
    chk("timer clear", inr(q, 0, 1), 32'h1);
    rstn <= 1'h0;
    @(posedge clk);
    rstn <= 1'h1;
    bus(1'h0, OFS_CTRL, 32'h0, q);
    chk("reset ctrl", q, 32'h0);
    $display("timer and reset done");
    // Automatic gate of 1 ms counting IF edges
    bus(1'h1, OFS_CTRL, 32'h21, q);
    bus(1'h0, OFS_STAT, 32'h0, q);
    chk("auto busy", q[B_BUSY], 1'h1);
    wait_idle(40000);
    bus(1'h0, OFS_RSLT, 32'h0, q);
    r = 32'(GATE0_TK * tk / 20);
    chk("auto count", inr(q, r - 2, r + 2), 32'h1);
    repeat (200) @(posedge clk);
    bus(1'h0, OFS_RSLT, 32'h0, r);
    chk("auto stopped", r, q);
    $display("auto done");
    give_verdict();
  end
endmodule
